//--- rtl/conv_params.svh
// Register indices, field positions and reset values of the converter block
`ifndef CONV_PARAMS_SVH
`define CONV_PARAMS_SVH

`define IDX_SYNC       10'h1FF
`define IDX_MODE       10'h200
`define IDX_DEC        10'h201
`define IDX_OFFS       10'h228
`define IDX_FDCTL      10'h245
`define IDX_UPLO       10'h247
`define IDX_UPHI       10'h248
`define IDX_LOLO       10'h249
`define IDX_LOHI       10'h24A
`define IDX_DWLO       10'h24B
`define IDX_DWHI       10'h24C
`define IDX_ISTAT      10'h300
`define IDX_IMASK      10'h301
`define IDX_STATE      10'h302

`define SYNC_MODE_BIT  0
`define REAL_ONLY_BIT  5
`define APP_MSB        3
`define DEC_MSB        2
`define FD_FORCE_BIT   3
`define FD_FVAL_BIT    2
`define FD_EN_BIT      0
`define THR_HI_MSB     4

`define MASK_SYNC      8'h01
`define MASK_MODE      8'hEF
`define MASK_DEC       8'h07
`define MASK_FDCTL     8'h0D
`define MASK_HI        8'h1F
`define MASK_IRQ       8'h07
`define RST_BYTE       8'h00

`define APP_FULL       4'h0
`define APP_ONE        4'h1
`define APP_TWO        4'h2
`define SYNC_STAMP     1'h1

`define IRQ_SYSREF     0
`define IRQ_LINK       1
`define IRQ_FD         2

`define RESP_OKAY      2'h0
`define RESP_DECERR    2'h3

`endif

//--- rtl/conv_pkg.sv
// Shared types and decode function of the converter block
package conv_pkg;

  typedef struct packed {
    logic       sysref_meta;
    logic       sysref_sync;
    logic       sysref_prev;
    logic [3:0] div_cnt;
    logic [3:0] div_phase;
    logic       link_drop;
    logic       sysref_evt;
    logic       stamp_pend;
  } sync_state_t;

  typedef struct packed {
    logic       aw_got;
    logic [9:0] aw_idx;
    logic       w_got;
    logic [7:0] w_byte;
    logic       w_lane0;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [7:0] rbyte;
    logic [1:0] rresp;
    logic [7:0] sync_sel;
    logic [7:0] app_mode;
    logic [7:0] dec_sel;
    logic [7:0] offset;
    logic [7:0] fd_ctl;
    logic [7:0] up_lo;
    logic [7:0] up_hi;
    logic [7:0] lo_lo;
    logic [7:0] lo_hi;
    logic [7:0] dw_lo;
    logic [7:0] dw_hi;
    logic [7:0] istat;
    logic [7:0] imask;
  } regs_state_t;

  // Last divider count for a decimation code; unused codes decimate by 1
  function automatic logic [3:0] dec_last(input logic [2:0] code);
    unique case (code)
      3'h1:    dec_last = 4'h1;
      3'h2:    dec_last = 4'h3;
      3'h3:    dec_last = 4'h7;
      3'h4:    dec_last = 4'hF;
      default: dec_last = 4'h0;
    endcase
  endfunction

endpackage

//--- rtl/sync_divider_unit.sv
// Reference pulse synchroniser, sample divider and timestamp marker
`timescale 1ns/1ps
`include "conv_params.svh"
module sync_divider_unit (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Reference pulse pin and samples
  input  wire logic       sysref_pin,
  input  wire logic       sample_valid,
  // Configuration
  input  wire logic       sync_mode,
  input  wire logic [2:0] dec_code,
  // Results
  output logic            sample_take,
  output logic            stamp_now,
  output logic            link_drop,
  output logic            sysref_evt,
  output logic [3:0]      div_phase
);
  conv_pkg::sync_state_t s_r;
  conv_pkg::sync_state_t s_nxt;
  logic                  edge_seen;
  logic [3:0]            last;

  always_comb begin
    s_nxt = s_r;
    last = conv_pkg::dec_last(dec_code);
    s_nxt.sysref_meta = sysref_pin;
    s_nxt.sysref_sync = s_r.sysref_meta;
    s_nxt.sysref_prev = s_r.sysref_sync;
    edge_seen = s_r.sysref_sync & ~s_r.sysref_prev;
    s_nxt.link_drop = 1'b0;
    s_nxt.sysref_evt = edge_seen;
    if (sample_valid) begin
      s_nxt.div_cnt = (s_r.div_cnt >= last) ? 4'h0 : s_r.div_cnt + 4'h1;
      s_nxt.stamp_pend = 1'b0;
    end
    if (edge_seen) begin
      s_nxt.div_phase = s_r.div_cnt;
      if (sync_mode == `SYNC_STAMP) begin
        s_nxt.stamp_pend = 1'b1;
      end else begin
        s_nxt.div_cnt = 4'h0;
        s_nxt.link_drop = (s_r.div_cnt != 4'h0);
      end
    end
    if (!aresetn) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge aclk) begin
    s_r <= s_nxt;
  end

  // In timestamp mode the divider and link are left alone
  assign sample_take = sample_valid && (s_r.div_cnt >= last);
  assign stamp_now   = sample_valid && s_r.stamp_pend;
  assign link_drop   = s_r.link_drop;
  assign sysref_evt  = s_r.sysref_evt;
  assign div_phase   = s_r.div_phase;
endmodule

//--- rtl/fast_detect_unit.sv
// Offset adder, magnitude threshold detector and threshold flag pin
`timescale 1ns/1ps
module fast_detect_unit #(
  parameter int SAMPLE_W = 14,
  parameter int DWELL_W  = 16
) (
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // Sample stream
  input  wire logic [SAMPLE_W-1:0]    sample_in,
  input  wire logic                   sample_valid,
  input  wire logic                   sample_take,
  input  wire logic                   stamp_now,
  // Configuration
  input  wire logic [7:0]             offset,
  input  wire logic                   fd_enable,
  input  wire logic                   fd_force,
  input  wire logic                   fd_force_value,
  input  wire logic [SAMPLE_W-2:0]    upper_thr,
  input  wire logic [SAMPLE_W-2:0]    lower_thr,
  input  wire logic [DWELL_W-1:0]     dwell,
  // Results
  output logic [SAMPLE_W-1:0]         sample_out,
  output logic                        sample_out_valid,
  output logic                        sample_out_stamp,
  output logic                        threshold_flag_pin,
  output logic                        fd_rise
);
  typedef struct packed {
    logic [SAMPLE_W-1:0] data;
    logic                valid;
    logic                stamp;
    logic                det;
    logic                pin;
    logic                rise;
    logic [DWELL_W-1:0]  cnt;
  } fd_state_t;

  localparam logic signed [SAMPLE_W:0] MAXV =
    (SAMPLE_W+1)'(2**(SAMPLE_W-1)-1);
  localparam logic signed [SAMPLE_W:0] MINV =
    (SAMPLE_W+1)'(-(2**(SAMPLE_W-1)));
  localparam logic [SAMPLE_W-2:0] MAGMAX = '1;

  fd_state_t                 s_r;
  fd_state_t                 s_nxt;
  logic signed [SAMPLE_W:0]  sum;
  logic signed [SAMPLE_W-1:0] sat;
  logic [SAMPLE_W-1:0]       mag;
  logic [SAMPLE_W-2:0]       mag13;

  always_comb begin
    s_nxt = s_r;
    sum = $signed({sample_in[SAMPLE_W-1], sample_in})
        + (SAMPLE_W+1)'(signed'(offset));
    if (sum > MAXV) begin
      sat = MAXV[SAMPLE_W-1:0];
    end else if (sum < MINV) begin
      sat = MINV[SAMPLE_W-1:0];
    end else begin
      sat = sum[SAMPLE_W-1:0];
    end
    mag = sat[SAMPLE_W-1] ? SAMPLE_W'(-sat) : SAMPLE_W'(sat);
    mag13 = mag[SAMPLE_W-1] ? MAGMAX : mag[SAMPLE_W-2:0];
    s_nxt.valid = sample_take;
    s_nxt.rise = 1'b0;
    if (sample_take) begin
      s_nxt.data = sat;
      s_nxt.stamp = stamp_now;
    end
    if (!fd_enable) begin
      s_nxt.det = 1'b0;
      s_nxt.cnt = '0;
    end else if (sample_valid) begin
      if (mag13 > upper_thr) begin
        s_nxt.det = 1'b1;
        s_nxt.cnt = dwell;
      end else if (mag13 >= lower_thr) begin
        s_nxt.cnt = dwell;
      end else if (s_r.det) begin
        if (s_r.cnt == '0) begin
          s_nxt.det = 1'b0;
        end else begin
          s_nxt.cnt = s_r.cnt - DWELL_W'(1);
        end
      end
    end
    if (fd_force) begin
      s_nxt.pin = fd_force_value;
    end else begin
      s_nxt.pin = fd_enable & s_nxt.det;
    end
    s_nxt.rise = s_nxt.pin & ~s_r.pin;
    if (!aresetn) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge aclk) begin
    s_r <= s_nxt;
  end

  assign sample_out         = s_r.data;
  assign sample_out_valid   = s_r.valid;
  assign sample_out_stamp   = s_r.stamp;
  assign threshold_flag_pin = s_r.pin;
  assign fd_rise            = s_r.rise;
endmodule

//--- rtl/converter_mode_fast_detect_regs.sv
// Converter mode, sync and fast-detect registers behind an AXI4-Lite slave
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "conv_params.svh"
module converter_mode_fast_detect_regs #(
  parameter int ADDR_W   = 12,
  parameter int SAMPLE_W = 14,
  parameter int DWELL_W  = 16
) (
  // Clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]          s_axi_awprot,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]          s_axi_arprot,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Reference pulse pin
  input  wire logic                sysref_pin,
  // Sample stream in
  input  wire logic [SAMPLE_W-1:0] sample_in,
  input  wire logic                sample_valid,
  // Sample stream out
  output logic [SAMPLE_W-1:0]      sample_out,
  output logic                     sample_out_valid,
  output logic                     sample_out_stamp,
  // Data path configuration
  output logic                     real_only,
  output logic                     full_bandwidth,
  output logic                     down_converter_channel0_en,
  output logic                     down_converter_channel1_en,
  output logic [2:0]               decimation_code,
  // Link and flag pin
  output logic                     link_drop,
  output logic                     threshold_flag_pin,
  // Interrupt
  output logic                     irq
);
  conv_pkg::regs_state_t s_r;
  conv_pkg::regs_state_t s_nxt;

  logic           sample_take;
  logic           stamp_now;
  logic           sysref_evt;
  logic [3:0]     div_phase;
  logic           fd_rise;
  logic           link_drop_i;
  logic           flag_pin_i;
  logic [7:0]     events;
  logic [7:0]     clr;
  logic [7:0]     state_byte;
  logic [8:0]     rd;
  logic [7:0]     wb;
  logic           wr_fire;
  logic [8:0]     wr_look;

  // Register read decode: returns hit bit and the byte
  function automatic logic [8:0] read_reg(
    input conv_pkg::regs_state_t s,
    input logic [9:0]            idx,
    input logic [7:0]            st
  );
    read_reg = {1'b1, `RST_BYTE};
    unique case (idx)
      `IDX_SYNC:  read_reg[7:0] = s.sync_sel;
      `IDX_MODE:  read_reg[7:0] = s.app_mode;
      `IDX_DEC:   read_reg[7:0] = s.dec_sel;
      `IDX_OFFS:  read_reg[7:0] = s.offset;
      `IDX_FDCTL: read_reg[7:0] = s.fd_ctl;
      `IDX_UPLO:  read_reg[7:0] = s.up_lo;
      `IDX_UPHI:  read_reg[7:0] = s.up_hi;
      `IDX_LOLO:  read_reg[7:0] = s.lo_lo;
      `IDX_LOHI:  read_reg[7:0] = s.lo_hi;
      `IDX_DWLO:  read_reg[7:0] = s.dw_lo;
      `IDX_DWHI:  read_reg[7:0] = s.dw_hi;
      `IDX_ISTAT: read_reg[7:0] = s.istat;
      `IDX_IMASK: read_reg[7:0] = s.imask;
      `IDX_STATE: read_reg[7:0] = st;
      default:    read_reg = {1'b0, `RST_BYTE};
    endcase
  endfunction

  always_comb begin
    s_nxt = s_r;
    clr = `RST_BYTE;
    wb = s_r.w_byte;
    wr_fire = s_r.aw_got && s_r.w_got && !s_r.bvalid;
    wr_look = read_reg(s_r, s_r.aw_idx, state_byte);
    // Address and data are taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.aw_idx = s_axi_awaddr[ADDR_W-1:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.w_byte = s_axi_wdata[7:0];
      s_nxt.w_lane0 = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = `RESP_OKAY;
      if (!wr_look[8]) begin
        s_nxt.bresp = `RESP_DECERR;
      end else if (s_r.w_lane0) begin
        unique case (s_r.aw_idx)
          `IDX_SYNC:  s_nxt.sync_sel = wb & `MASK_SYNC;
          `IDX_MODE:  s_nxt.app_mode = wb & `MASK_MODE;
          `IDX_DEC:   s_nxt.dec_sel = wb & `MASK_DEC;
          `IDX_OFFS:  s_nxt.offset = wb;
          `IDX_FDCTL: s_nxt.fd_ctl = wb & `MASK_FDCTL;
          `IDX_UPLO:  s_nxt.up_lo = wb;
          `IDX_UPHI:  s_nxt.up_hi = wb & `MASK_HI;
          `IDX_LOLO:  s_nxt.lo_lo = wb;
          `IDX_LOHI:  s_nxt.lo_hi = wb & `MASK_HI;
          `IDX_DWLO:  s_nxt.dw_lo = wb;
          `IDX_DWHI:  s_nxt.dw_hi = wb;
          `IDX_ISTAT: clr = wb & `MASK_IRQ;
          `IDX_IMASK: s_nxt.imask = wb & `MASK_IRQ;
          default:    clr = `RST_BYTE;
        endcase
      end
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    // Read answers one cycle after the address is taken
    rd = read_reg(s_r, s_axi_araddr[ADDR_W-1:2], state_byte);
    if (s_axi_arvalid && s_axi_arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rbyte = rd[7:0];
      s_nxt.rresp = rd[8] ? `RESP_OKAY : `RESP_DECERR;
    end else if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    // Sticky status: a new event wins over a clear in the same cycle
    s_nxt.istat = (s_r.istat & ~clr) | events;
    if (!aresetn) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge aclk) begin
    s_r <= s_nxt;
  end

  always_comb begin
    events = `RST_BYTE;
    events[`IRQ_SYSREF] = sysref_evt;
    events[`IRQ_LINK] = link_drop_i;
    events[`IRQ_FD] = fd_rise;
    state_byte = {div_phase, 2'h0,
                  s_r.sync_sel[`SYNC_MODE_BIT], flag_pin_i};
  end

  sync_divider_unit u_sync (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .sysref_pin   (sysref_pin),
    .sample_valid (sample_valid),
    .sync_mode    (s_r.sync_sel[`SYNC_MODE_BIT]),
    .dec_code     (s_r.dec_sel[`DEC_MSB:0]),
    .sample_take  (sample_take),
    .stamp_now    (stamp_now),
    .link_drop    (link_drop_i),
    .sysref_evt   (sysref_evt),
    .div_phase    (div_phase)
  );

  fast_detect_unit #(
    .SAMPLE_W (SAMPLE_W),
    .DWELL_W  (DWELL_W)
  ) u_fd (
    .aclk               (aclk),
    .aresetn            (aresetn),
    .sample_in          (sample_in),
    .sample_valid       (sample_valid),
    .sample_take        (sample_take),
    .stamp_now          (stamp_now),
    .offset             (s_r.offset),
    .fd_enable          (s_r.fd_ctl[`FD_EN_BIT]),
    .fd_force           (s_r.fd_ctl[`FD_FORCE_BIT]),
    .fd_force_value     (s_r.fd_ctl[`FD_FVAL_BIT]),
    .upper_thr          ({s_r.up_hi[`THR_HI_MSB:0], s_r.up_lo}),
    .lower_thr          ({s_r.lo_hi[`THR_HI_MSB:0], s_r.lo_lo}),
    .dwell              ({s_r.dw_hi, s_r.dw_lo}),
    .sample_out         (sample_out),
    .sample_out_valid   (sample_out_valid),
    .sample_out_stamp   (sample_out_stamp),
    .threshold_flag_pin (flag_pin_i),
    .fd_rise            (fd_rise)
  );

  // Bus handshakes
  assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
  assign s_axi_wready  = !s_r.w_got && !s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rdata   = {24'h000000, s_r.rbyte};
  assign s_axi_rresp   = s_r.rresp;
  assign s_axi_rvalid  = s_r.rvalid;

  // Mode decode
  assign real_only = s_r.app_mode[`REAL_ONLY_BIT];
  assign full_bandwidth =
    (s_r.app_mode[`APP_MSB:0] == `APP_FULL);
  assign down_converter_channel0_en =
    (s_r.app_mode[`APP_MSB:0] == `APP_ONE) ||
    (s_r.app_mode[`APP_MSB:0] == `APP_TWO);
  assign down_converter_channel1_en =
    (s_r.app_mode[`APP_MSB:0] == `APP_TWO);
  assign decimation_code = s_r.dec_sel[`DEC_MSB:0];

  assign link_drop          = link_drop_i;
  assign threshold_flag_pin = flag_pin_i;
  assign irq                = |(s_r.istat & s_r.imask);
endmodule

//--- bench/conv_regs_props.sv
// Port checks of the converter register block
`timescale 1ns/1ps
module conv_regs_props (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Data path
  input wire logic        sample_valid,
  input wire logic        sample_out_valid,
  input wire logic        full_bandwidth,
  input wire logic        down_converter_channel0_en,
  input wire logic        down_converter_channel1_en,
  input wire logic [2:0]  decimation_code,
  input wire logic        link_drop
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_answer_s;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  write_latency_a: assert property (wr_taken_s |=> wr_answer_s)
    else $error("write response not two cycles after request");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read data not one cycle after request");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready
    && s_axi_rdata[31:8] == 24'h0)
    else $error("read address taken while data pending");
  write_block_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  channel_decode_a: assert property (full_bandwidth |->
    !down_converter_channel0_en && !down_converter_channel1_en)
    else $error("full band with a channel enabled");
  two_channel_a: assert property (down_converter_channel1_en |->
    down_converter_channel0_en)
    else $error("channel one without channel zero");
  full_rate_a: assert property (sample_valid &&
    decimation_code == 3'h0 |=> sample_out_valid)
    else $error("full rate sample not passed");
  out_cause_a: assert property (sample_out_valid |->
    $past(sample_valid))
    else $error("output without input sample");
  link_pulse_a: assert property (link_drop |=> !link_drop)
    else $error("link drop longer than one cycle");
endmodule
bind converter_mode_fast_detect_regs conv_regs_props u_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .sample_valid, .sample_out_valid, .full_bandwidth,
  .down_converter_channel0_en, .down_converter_channel1_en,
  .decimation_code, .link_drop);

//--- bench/converter_mode_fast_detect_regs_bench.sv
// Self-checking bench of the converter register block
`timescale 1ns/1ps
`include "conv_params.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module converter_mode_fast_detect_regs_bench;
  logic        aclk = 1'b0, aresetn = 1'b0, sysref_pin = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, sample_valid = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, sample_out_valid, sample_out_stamp, irq;
  logic        real_only, full_bandwidth, link_drop, threshold_flag_pin;
  logic        down_converter_channel0_en, down_converter_channel1_en;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  decimation_code;
  logic [13:0] sample_in = '0, sample_out, last_out;
  int          bad_count = 0, n_tests = 0, cyc = 0;
  int          n_out = 0, n_stamp = 0, n_drop = 0;
  logic [9:0]  reg_idx [6] = '{`IDX_SYNC, `IDX_MODE, `IDX_DEC, `IDX_OFFS,
                                `IDX_FDCTL, `IDX_UPLO};
  logic [7:0]  reg_msk [6] = '{8'h01, 8'hEF, 8'h07, 8'hFF, 8'h0D, 8'hFF};
  logic [2:0]  app_exp [3] = '{3'h4, 3'h2, 3'h3};
  logic [7:0]  off_t [5] = '{8'hFF, 8'h7F, 8'h80, 8'h7F, 8'h80};
  logic [13:0] in_t [5] = '{14'h000A, 14'h000A, 14'h000A, 14'h1FFF, 14'h2000};
  logic [13:0] out_t [5] = '{14'h0009, 14'h0089, 14'h3F8A, 14'h1FFF, 14'h2000};

  converter_mode_fast_detect_regs uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sysref_pin,
    .sample_in, .sample_valid, .sample_out, .sample_out_valid,
    .sample_out_stamp, .real_only, .full_bandwidth,
    .down_converter_channel0_en, .down_converter_channel1_en,
    .decimation_code, .link_drop, .threshold_flag_pin, .irq);

  always #5 aclk = ~aclk;

  always @(posedge aclk) begin
    cyc++;
    if (sample_out_valid) begin
      n_out++;
      last_out = sample_out;
    end
    if (sample_out_stamp) n_stamp++;
    if (link_drop) n_drop++;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("tests %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d,
                    input logic [1:0] er);
    logic a, w;
    a = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(a && w)) begin
      @(posedge aclk);
      if (!a && s_axi_awready) begin
        a = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, er)
  endtask

  task automatic rd(input logic [9:0] idx, input logic [7:0] ed,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, {24'h0, ed})
    `CHK(s_axi_rresp, er)
  endtask

  task automatic smp(input logic [13:0] v, input int n);
    repeat (n) begin
      @(posedge aclk);
      sample_in <= v;
      sample_valid <= 1'b1;
    end
    @(posedge aclk);
    sample_valid <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask

  task automatic pulse_ref();
    @(posedge aclk);
    sysref_pin <= 1'b1;
    repeat (3) @(posedge aclk);
    sysref_pin <= 1'b0;
    repeat (6) @(posedge aclk);
  endtask

  task automatic fd(input logic [7:0] c);
    wr(`IDX_FDCTL, c, `RESP_OKAY);
    repeat (2) @(posedge aclk);
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) rd(reg_idx[i], 8'h00, `RESP_OKAY);
    `CHK(full_bandwidth, 1'b1)
    for (int i = 0; i < 6; i++) begin
      wr(reg_idx[i], 8'hFF, `RESP_OKAY);
      rd(reg_idx[i], reg_msk[i], `RESP_OKAY);
    end
    `CHK(real_only, 1'b1)
    rd(10'h010, 8'h00, `RESP_DECERR);
    wr(10'h010, 8'h5A, `RESP_DECERR);
    done("registers");
    for (int m = 0; m < 3; m++) begin
      wr(`IDX_MODE, 8'(m), `RESP_OKAY);
      `CHK({full_bandwidth, down_converter_channel0_en,
            down_converter_channel1_en}, app_exp[m])
    end
    `CHK(real_only, 1'b0)
    done("modes");
    wr(`IDX_SYNC, 8'h01, `RESP_OKAY);
    for (int c = 0; c < 5; c++) begin
      wr(`IDX_DEC, 8'(c), `RESP_OKAY);
      n_out = 0;
      smp(14'h0005, 16);
      `CHK(n_out, 16 >> c)
    end
    wr(`IDX_DEC, 8'h00, `RESP_OKAY);
    for (int k = 0; k < 5; k++) begin
      wr(`IDX_OFFS, off_t[k], `RESP_OKAY);
      smp(in_t[k], 1);
      `CHK(last_out, out_t[k])
    end
    wr(`IDX_OFFS, 8'h00, `RESP_OKAY);
    s_axi_wstrb <= 4'h0;
    wr(`IDX_OFFS, 8'h55, `RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(`IDX_OFFS, 8'h00, `RESP_OKAY);
    done("data path");
    n_stamp = 0;
    n_drop = 0;
    pulse_ref();
    smp(14'h0005, 2);
    `CHK(n_stamp, 1)
    `CHK(n_drop, 0)
    wr(`IDX_SYNC, 8'h00, `RESP_OKAY);
    wr(`IDX_DEC, 8'h02, `RESP_OKAY);
    pulse_ref();
    n_drop = 0;
    smp(14'h0005, 1);
    pulse_ref();
    `CHK(n_drop, 1)
    rd(`IDX_STATE, 8'h11, `RESP_OKAY);
    n_out = 0;
    smp(14'h0005, 3);
    `CHK(n_out, 0)
    smp(14'h0005, 1);
    `CHK(n_out, 1)
    pulse_ref();
    `CHK(n_drop, 1)
    rd(`IDX_ISTAT, 8'h07, `RESP_OKAY);
    wr(`IDX_IMASK, 8'h02, `RESP_OKAY);
    `CHK(irq, 1'b1)
    wr(`IDX_ISTAT, 8'h02, `RESP_OKAY);
    `CHK(irq, 1'b0)
    wr(`IDX_IMASK, 8'h01, `RESP_OKAY);
    `CHK(irq, 1'b1)
    wr(`IDX_ISTAT, 8'h01, `RESP_OKAY);
    `CHK(irq, 1'b0)
    wr(`IDX_ISTAT, 8'h04, `RESP_OKAY);
    done("sync and interrupt");
    wr(`IDX_DEC, 8'h00, `RESP_OKAY);
    wr(`IDX_UPLO, 8'h64, `RESP_OKAY);
    wr(`IDX_LOLO, 8'h32, `RESP_OKAY);
    wr(`IDX_DWLO, 8'h02, `RESP_OKAY);
    fd(8'h00);
    smp(14'h01F4, 1);
    `CHK(threshold_flag_pin, 1'b0)
    smp(14'h0000, 3);
    fd(8'h0C);
    `CHK(threshold_flag_pin, 1'b1)
    fd(8'h08);
    `CHK(threshold_flag_pin, 1'b0)
    fd(8'h01);
    smp(14'h0064, 1);
    `CHK(threshold_flag_pin, 1'b0)
    smp(14'h0065, 1);
    `CHK(threshold_flag_pin, 1'b1)
    smp(14'h0000, 2);
    `CHK(threshold_flag_pin, 1'b1)
    smp(14'h0000, 1);
    `CHK(threshold_flag_pin, 1'b0)
    rd(`IDX_ISTAT, 8'h04, `RESP_OKAY);
    wr(`IDX_IMASK, 8'h04, `RESP_OKAY);
    `CHK(irq, 1'b1)
    wr(`IDX_ISTAT, 8'h04, `RESP_OKAY);
    `CHK(irq, 1'b0)
    done("fast detect");
    conclude();
  end
endmodule
